/* File: drum_pkg.sv */
// constants, states and carrier structs for the drum transfer controller
// assumes a single 250 MHz clock domain shared by all design files
package drum_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int WORD_TIME_NS = 8500;
  localparam int WORD_CYCLES = (WORD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] WORD_LAST = 12'(WORD_CYCLES - 1);
  localparam int ACK_TIME_NS = 6000;
  localparam int ACK_CYCLES = ACK_TIME_NS / CLK_PERIOD_NS;
  localparam logic [10:0] ACK_LAST = 11'(ACK_CYCLES - 1);

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int WORD_W = 18;
  localparam int POS_W = 12;
  localparam int FIELD_W = 5;
  localparam int FIELDS = 32;
  localparam int CORE_W = 16;
  localparam int ADDR_W = 13;
  localparam int LEVEL_W = 2 * WORD_W + 1 + FIELDS;

  // ----------------------------------------
  // io word fields (io bit n sits at index 17-n)
  // ----------------------------------------
  localparam int CTRL_BIT = 17;
  localparam int FIELD_MSB = 16;
  localparam int FIELD_LSB = 12;
  localparam int POS_MSB = 11;
  localparam int CORE_MSB = 15;
  localparam int BANK_MSB = 15;
  localparam int BANK_LSB = 14;
  localparam int ADDR_MSB = 12;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [11:0] POS_RESET = 12'h000;
  localparam logic [17:0] WORD_RESET = 18'h00000;
  localparam logic [15:0] CORE_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_ACTIVE = 3'b100
  } xfer_state_e;

  typedef struct packed {
    logic transfer_request;
    logic read_req;
    logic write_req;
    logic [1:0] bank;
    logic [12:0] address;
    logic [17:0] data;
  } mem_out_s;

  typedef struct packed {
    logic read_enable;
    logic write_enable;
    logic [4:0] read_field;
    logic [4:0] write_field;
    logic write_strobe;
    logic write_parity;
    logic [17:0] write_word;
  } drum_out_s;

endpackage : drum_pkg

/* File: sync_edge.sv */
// two-stage synchroniser with rising edge detect on the synchronised level
// assumes pins are asynchronous to clk
`timescale 1ns/1ns
module sync_edge #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pins in, synchronised out
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);

  logic [W-1:0] meta;
  logic [W-1:0] held;
  logic [W-1:0] prev;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta <= '0;
      held <= '0;
      prev <= '0;
    end
    else
    begin
      meta <= pin;
      held <= meta;
      prev <= held;
    end
  end

  assign level = held;
  assign rise = held & ~prev;

endmodule : sync_edge

/* File: word_timer.sv */
// word time generator, one phase a pulse per drum word time
// assumes clk at the rate given in drum_pkg
`timescale 1ns/1ns
module word_timer (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // word timing
  output logic phase_a
);

  logic [11:0] count;
  wire logic wrap;

  assign wrap = (count == drum_pkg::WORD_LAST);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      count <= 12'h000;
      phase_a <= 1'b0;
    end
    else
    begin
      count <= wrap ? 12'h000 : count + 12'h001;
      phase_a <= wrap;
    end
  end

endmodule : word_timer

/* File: drum_transfer_controller.sv */
// drum transfer controller: instruction decode, position match, word moves
// assumes memory controller logic runs on clk; host and drum pins are asynchronous
//
// Summary of operation
// - request flip-flop held for whole transfer
// - ack-watch set per request, cleared by ack
// - readback pulse sets sync, strobes position out
// - break pulse sets sync; match gives break
// - read parity captured and checked against regenerated
// - word-count loads write flag, field, count
// - initial-address loads read flag, field, start
// - core-location loads location, waits for position
// - bits 2-3 bank, bits 5-17 address
// - request cleared after last word moved
// - break-address loads like initial-address, plus break
// - readback word: status, parity, transfer, position
// - parity mismatch sets parity error flag
// - interrupted transfer sets transfer error flag
// - 12-bit position advances each word time
// - write buffer feeds drum and parity check
// - read buffer holds drum word, restores core
// - lockout switch inhibits writing its field
// - bad-parity test inverts first written parity
// - read and write together exchange words
`timescale 1ns/1ns
module drum_transfer_controller (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // host io bus
  input wire logic [17:0] io_in,
  input wire logic initial_address_instr,
  input wire logic word_count_instr,
  input wire logic core_location_instr,
  input wire logic break_address_instr,
  input wire logic position_readback_instr,
  output logic [17:0] io_out,
  output logic io_strobe,
  output logic seq_break_return,
  output logic busy,
  output logic error_status,
  output logic parity_error_flag,
  output logic transfer_error_flag,
  // panel
  input wire logic [31:0] field_lockout,
  input wire logic bad_parity_test,
  // drum heads
  input wire logic [17:0] drum_read_word,
  input wire logic drum_read_parity,
  output drum_pkg::drum_out_s drum_out,
  // memory controller
  input wire logic mem_addr_ack,
  input wire logic [17:0] mem_data_in,
  output drum_pkg::mem_out_s mem_out
);

  // ----------------------------------------
  // input synchronisers and word timing
  // ----------------------------------------
  wire logic [17:0] io_s;
  wire logic [17:0] rword_s;
  wire logic rpar_s;
  wire logic [31:0] lock_s;
  wire logic [5:0] pulse;
  wire logic tick;

  sync_edge #(.W(drum_pkg::LEVEL_W)) u_levels (
    .clk(clk),
    .reset(reset),
    .pin({field_lockout, drum_read_parity, drum_read_word, io_in}),
    .level({lock_s, rpar_s, rword_s, io_s}),
    .rise()
  );

  sync_edge #(.W(6)) u_pulses (
    .clk(clk),
    .reset(reset),
    .pin({bad_parity_test, position_readback_instr, break_address_instr,
          core_location_instr, word_count_instr, initial_address_instr}),
    .level(),
    .rise(pulse)
  );

  word_timer u_timer (
    .clk(clk),
    .reset(reset),
    .phase_a(tick)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  drum_pkg::xfer_state_e state;
  drum_pkg::xfer_state_e next_state;
  logic read_ctrl;
  logic write_ctrl;
  logic [4:0] read_field;
  logic [4:0] write_field;
  logic [11:0] start_position;
  logic [11:0] word_counter;
  logic [15:0] core_location;
  logic [11:0] position;
  logic [17:0] write_buffer;
  logic [17:0] read_buffer;
  logic read_parity_bit;
  logic check_pending;
  logic transfer_request;
  logic rd_req;
  logic wr_req;
  logic ack_watch;
  logic [10:0] ack_timer;
  logic break_sync;
  logic break_armed;
  logic readback_sync;
  logic bad_parity_armed;
  logic first_word;
  logic write_strobe;
  logic write_parity;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic do_init = pulse[0];
  wire logic do_wc = pulse[1];
  wire logic do_core = pulse[2];
  wire logic do_brk = pulse[3];
  wire logic do_rb = pulse[4];
  wire logic bad_rise = pulse[5];
  wire logic load_read = do_init | do_brk;
  wire logic waiting_for_start = (state == drum_pkg::ST_WAIT);
  wire logic transfer_active = (state == drum_pkg::ST_ACTIVE);
  wire logic pos_match = (position == start_position);
  wire logic start_now = waiting_for_start & tick & pos_match;
  wire logic word_issue = tick & (start_now | transfer_active);
  wire logic ack = mem_addr_ack & ack_watch & transfer_active;
  wire logic done = ack & (word_counter == 12'h001);
  wire logic timeout = ack_watch & transfer_active & ~mem_addr_ack
                       & (ack_timer == drum_pkg::ACK_LAST);
  wire logic interrupt = do_core & transfer_active;
  wire logic brk_match = break_armed & tick & pos_match;
  wire logic inject = bad_parity_armed & first_word;
  wire logic [17:0] check_word = write_ctrl ? read_buffer : write_buffer;
  wire logic regen_parity = ~^check_word;
  wire logic pe_set = check_pending & (regen_parity != read_parity_bit);
  wire logic te_set = timeout | interrupt;
  wire logic next_pe = pe_set | (parity_error_flag & ~load_read);
  wire logic next_te = te_set | (transfer_error_flag & ~load_read);
  wire logic write_allowed = ~lock_s[write_field];

  always_comb
  begin
    next_state = state;
    case (state)
      drum_pkg::ST_IDLE: if (do_core) next_state = drum_pkg::ST_WAIT;
      drum_pkg::ST_WAIT: if (start_now) next_state = drum_pkg::ST_ACTIVE;
      drum_pkg::ST_ACTIVE:
        if (interrupt) next_state = drum_pkg::ST_WAIT;
        else if (done || timeout) next_state = drum_pkg::ST_IDLE;
      default: next_state = drum_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      state <= drum_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // ----------------------------------------
  // setup registers and counters
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      read_ctrl <= 1'b0;
      read_field <= '0;
      start_position <= drum_pkg::POS_RESET;
      write_ctrl <= 1'b0;
      write_field <= '0;
      word_counter <= drum_pkg::POS_RESET;
      core_location <= drum_pkg::CORE_RESET;
      position <= drum_pkg::POS_RESET;
    end
    else
    begin
      if (load_read)
      begin
        read_ctrl <= io_s[drum_pkg::CTRL_BIT];
        read_field <= io_s[drum_pkg::FIELD_MSB:drum_pkg::FIELD_LSB];
        start_position <= io_s[drum_pkg::POS_MSB:0];
      end
      if (do_wc)
      begin
        write_ctrl <= io_s[drum_pkg::CTRL_BIT];
        write_field <= io_s[drum_pkg::FIELD_MSB:drum_pkg::FIELD_LSB];
        word_counter <= io_s[drum_pkg::POS_MSB:0];
      end
      else if (ack)
        word_counter <= word_counter - 12'h001;
      if (do_core)
        core_location <= io_s[drum_pkg::CORE_MSB:0];
      else if (ack)
        core_location <= {core_location[15:13], core_location[12:0] + 13'h0001};
      if (tick)
        position <= position + 12'h001;
    end
  end

  // ----------------------------------------
  // request, ack watch, data buffers
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      transfer_request <= 1'b0;
      rd_req <= 1'b0;
      wr_req <= 1'b0;
      ack_watch <= 1'b0;
      ack_timer <= '0;
      first_word <= 1'b0;
    end
    else
    begin
      transfer_request <= start_now | (transfer_request & ~done & ~timeout & ~interrupt);
      rd_req <= (word_issue & read_ctrl) | (rd_req & ~ack & ~timeout);
      wr_req <= (word_issue & write_ctrl) | (wr_req & ~ack & ~timeout);
      ack_watch <= word_issue | (ack_watch & ~ack);
      if (word_issue)
        ack_timer <= '0;
      else if (ack_watch && ack_timer != drum_pkg::ACK_LAST)
        ack_timer <= ack_timer + 11'h001;
      first_word <= start_now | (first_word & ~ack);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      read_buffer <= drum_pkg::WORD_RESET;
      write_buffer <= drum_pkg::WORD_RESET;
      read_parity_bit <= 1'b0;
      check_pending <= 1'b0;
    end
    else
    begin
      if (word_issue && read_ctrl)
        read_buffer <= rword_s;
      else if (ack && !read_ctrl)
        read_buffer <= mem_data_in;
      if (word_issue && !write_ctrl)
        write_buffer <= rword_s;
      else if (ack && write_ctrl)
        write_buffer <= mem_data_in;
      if (word_issue)
        read_parity_bit <= rpar_s;
      check_pending <= word_issue & read_ctrl;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      write_strobe <= 1'b0;
      write_parity <= 1'b0;
      bad_parity_armed <= 1'b0;
    end
    else
    begin
      write_strobe <= ack & write_ctrl & write_allowed;
      if (ack && write_ctrl)
        write_parity <= ~^mem_data_in ^ inject;
      bad_parity_armed <= bad_rise | (bad_parity_armed & ~(ack & write_ctrl & first_word));
    end
  end

  // ----------------------------------------
  // errors, break and readback
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      parity_error_flag <= 1'b0;
      transfer_error_flag <= 1'b0;
      error_status <= 1'b0;
      busy <= 1'b0;
      break_sync <= 1'b0;
      break_armed <= 1'b0;
      seq_break_return <= 1'b0;
      readback_sync <= 1'b0;
      io_out <= drum_pkg::WORD_RESET;
      io_strobe <= 1'b0;
    end
    else
    begin
      parity_error_flag <= next_pe;
      transfer_error_flag <= next_te;
      error_status <= next_pe | next_te;
      busy <= do_core | do_brk | (busy & ~done & ~timeout & ~brk_match);
      break_sync <= do_brk | (break_sync & ~tick);
      break_armed <= do_brk | (break_armed & ~brk_match);
      seq_break_return <= brk_match;
      readback_sync <= do_rb | (readback_sync & ~tick);
      io_strobe <= do_rb;
      if (do_rb)
        io_out <= {error_status, parity_error_flag, transfer_error_flag, 3'h0, position};
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign mem_out = '{transfer_request: transfer_request, read_req: rd_req, write_req: wr_req,
                     bank: core_location[drum_pkg::BANK_MSB:drum_pkg::BANK_LSB],
                     address: core_location[drum_pkg::ADDR_MSB:0], data: read_buffer};
  assign drum_out = '{read_enable: read_ctrl, write_enable: write_ctrl,
                      read_field: read_field, write_field: write_field,
                      write_strobe: write_strobe, write_parity: write_parity,
                      write_word: write_buffer};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [11:0] watch_age;

  // cycles the ack watch has been open within the current word
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      watch_age <= 12'h000;
    else if (word_issue)
      watch_age <= 12'h000;
    else if (ack_watch && transfer_active && watch_age != 12'hFFF)
      watch_age <= watch_age + 12'h001;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_request;
    word_issue ##1 ack_watch;
  endsequence

  property p_rq_held;
    transfer_active && !$past(done) |-> transfer_request;
  endproperty
  a_rq_held: assert property (p_rq_held) else $error("request dropped in transfer");

  property p_ack_set;
    word_issue |-> s_request;
  endproperty
  a_ack_set: assert property (p_ack_set) else $error("ack watch not set");

  property p_ack_watch;
    transfer_active && ack_watch |-> watch_age <= {1'b0, drum_pkg::ACK_LAST};
  endproperty
  a_ack_watch: assert property (p_ack_watch) else $error("ack watch unresolved");

  property p_readback;
    do_rb |=> io_strobe && readback_sync && io_out[11:0] == $past(position);
  endproperty
  a_readback: assert property (p_readback) else $error("readback word wrong");

  property p_break;
    brk_match |=> seq_break_return && !busy;
  endproperty
  a_break: assert property (p_break) else $error("break return missing");

  property p_word_count;
    do_wc |=> word_counter == $past(io_s[11:0]) && write_ctrl == $past(io_s[17]);
  endproperty
  a_word_count: assert property (p_word_count) else $error("word count load wrong");

  property p_init;
    load_read |=> start_position == $past(io_s[11:0]) && read_field == $past(io_s[16:12]);
  endproperty
  a_init: assert property (p_init) else $error("initial address load wrong");

  property p_core;
    do_core && !transfer_active |=> mem_out.bank == $past(io_s[15:14]) && waiting_for_start;
  endproperty
  a_core: assert property (p_core) else $error("core location load wrong");

  property p_end;
    done |=> !transfer_request ##1 !transfer_request;
  endproperty
  a_end: assert property (p_end) else $error("request held after last word");

  property p_parity;
    pe_set |=> parity_error_flag && error_status;
  endproperty
  a_parity: assert property (p_parity) else $error("parity error not flagged");

  property p_timeout;
    timeout |=> transfer_error_flag && !transfer_request;
  endproperty
  a_timeout: assert property (p_timeout) else $error("transfer error not flagged");

  property p_position;
    tick |=> position == $past(position) + 12'h001;
  endproperty
  a_position: assert property (p_position) else $error("position did not advance");

  property p_lockout;
    ack && write_ctrl && lock_s[write_field] |=> !drum_out.write_strobe;
  endproperty
  a_lockout: assert property (p_lockout) else $error("write into locked field");

  property p_status;
    error_status == (parity_error_flag | transfer_error_flag);
  endproperty
  a_status: assert property (p_status) else $error("error status mismatch");

endmodule : drum_transfer_controller

/* File: mem_ctrl_model.sv */
// memory controller model: acks each drum word request after a set delay
// assumes drum_pkg is compiled first and one clock is shared with the design
`timescale 1ns/1ns
module mem_ctrl_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // drum side
  input wire drum_pkg::mem_out_s mem_out,
  output logic mem_addr_ack,
  output logic [17:0] mem_data_in,
  // scenario control
  input wire logic [11:0] ack_delay,
  input wire logic ack_off,
  output logic [17:0] stored_word
);
  logic [11:0] wait_cnt;
  logic served;
  wire logic req = mem_out.read_req | mem_out.write_req;
  wire logic want = req & ~served & ~ack_off;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mem_addr_ack <= 1'b0;
      mem_data_in <= 18'h00000;
      stored_word <= 18'h00000;
      wait_cnt <= 12'h000;
      served <= 1'b0;
    end
    else
    begin
      mem_addr_ack <= 1'b0;
      mem_data_in <= ~mem_data_in;
      if (want && wait_cnt == ack_delay)
      begin
        mem_addr_ack <= 1'b1;
        mem_data_in <= {5'h15, mem_out.address};
        if (mem_out.read_req)
          stored_word <= mem_out.data;
        served <= 1'b1;
        wait_cnt <= 12'h000;
      end
      else if (want)
        wait_cnt <= wait_cnt + 12'h001;
      if (!req)
        served <= 1'b0;
    end
  end
endmodule : mem_ctrl_model

/* File: tb_top.sv */
// testbench for the drum transfer controller: host tasks drive instructions
// assumes drum_pkg, the design files and mem_ctrl_model are compiled first
`timescale 1ns/1ns
module tb_top;
  localparam logic [17:0] DW = 18'h2C3A1;
  localparam int LIMIT = 90000;
  logic clk;
  logic reset;
  logic [17:0] io_in;
  logic [4:0] pins;
  logic [31:0] field_lockout;
  logic bad_parity_test;
  logic drum_par;
  logic [11:0] ack_delay;
  logic ack_off;
  logic [17:0] io_out;
  logic io_strobe;
  logic seq_break_return;
  logic busy;
  logic error_status;
  logic parity_error_flag;
  logic transfer_error_flag;
  drum_pkg::drum_out_s drum_out;
  drum_pkg::mem_out_s mem_out;
  logic mem_addr_ack;
  logic [17:0] mem_data_in;
  logic [17:0] stored_word;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int strobes = 0;
  int rise_cyc;

  drum_transfer_controller u_drum_transfer_controller (
    .clk(clk), .reset(reset), .io_in(io_in),
    .initial_address_instr(pins[0]), .word_count_instr(pins[1]),
    .core_location_instr(pins[2]), .break_address_instr(pins[3]),
    .position_readback_instr(pins[4]), .io_out(io_out), .io_strobe(io_strobe),
    .seq_break_return(seq_break_return), .busy(busy), .error_status(error_status),
    .parity_error_flag(parity_error_flag), .transfer_error_flag(transfer_error_flag),
    .field_lockout(field_lockout), .bad_parity_test(bad_parity_test),
    .drum_read_word(DW), .drum_read_parity(drum_par), .drum_out(drum_out),
    .mem_addr_ack(mem_addr_ack), .mem_data_in(mem_data_in), .mem_out(mem_out));

  mem_ctrl_model u_mem_ctrl_model (
    .clk(clk), .reset(reset), .mem_out(mem_out), .mem_addr_ack(mem_addr_ack),
    .mem_data_in(mem_data_in), .ack_delay(ack_delay), .ack_off(ack_off),
    .stored_word(stored_word));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (drum_out.write_strobe === 1'b1)
      strobes <= strobes + 1;
    if (cyc == LIMIT)
    begin
      bad_count++;
      close_out();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out();
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  function automatic logic probe(input int k);
    case (k)
      0: return mem_out.read_req | mem_out.write_req;
      1: return !busy;
      2: return io_strobe;
      3: return seq_break_return;
      4: return drum_out.write_strobe;
      default: return !(mem_out.read_req | mem_out.write_req);
    endcase
  endfunction : probe

  task automatic wait_for(input int k, output int n);
    n = 0;
    @(posedge clk);
    #1;
    while (probe(k) !== 1'b1 && n < 12000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("wait_limit", 18'h0, {17'h0, n == 12000});
  endtask : wait_for

  task automatic instr(input int k, input logic [17:0] w);
    @(posedge clk);
    io_in <= w;
    repeat (4) @(posedge clk);
    pins[k] <= 1'b1;
    repeat (4) @(posedge clk);
    pins[k] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : instr

  task automatic readback(output logic [17:0] w);
    int n;
    @(posedge clk);
    io_in <= 18'h00000;
    repeat (4) @(posedge clk);
    rise_cyc = cyc;
    pins[4] <= 1'b1;
    wait_for(2, n);
    w = io_out;
    repeat (3) @(posedge clk);
    pins[4] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : readback

  task automatic start(input int b, input logic rd, input logic wr, input logic [4:0] f,
                       input logic [11:0] cnt, input logic [15:0] core);
    logic [17:0] w;
    readback(w);
    instr(b, {rd, f, w[11:0] + 12'h003});
    instr(1, {wr, f, cnt});
    instr(2, {2'b00, core});
  endtask : start

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_readback();
    logic [17:0] a;
    logic [17:0] b;
    chk("idle_out", 18'h0, {io_out[17:2], busy, mem_out.transfer_request});
    readback(a);
    while (cyc != rise_cyc + 2120) @(posedge clk);
    readback(b);
    chk("pos_step", {6'h0, a[11:0] + 12'h001}, {6'h0, b[11:0]});
    chk("rb_flags", 18'h0, {b[17:12], 12'h0});
  endtask : t_readback

  task automatic t_read();
    int n;
    @(posedge clk);
    ack_delay <= 12'd3;
    start(0, 1'b1, 1'b0, 5'h05, 12'h002, 16'h8100);
    wait_for(0, n);
    chk("bank", 18'h2, {16'h0, mem_out.bank});
    chk("addr", 18'h0100, {5'h0, mem_out.address});
    chk("rq_rd_wr", 18'h6, {15'h0, mem_out.transfer_request, mem_out.read_req,
        mem_out.write_req});
    chk("rd_sel", 18'h25, {12'h0, drum_out.read_enable, drum_out.read_field});
    chk("rd_data", DW, mem_out.data);
    wait_for(5, n);
    wait_for(0, n);
    chk("addr2", 18'h0101, {5'h0, mem_out.address});
    chk("rq_held", 18'h1, {17'h0, mem_out.transfer_request});
    wait_for(1, n);
    chk("rq_end", 18'h0, {17'h0, mem_out.transfer_request});
    chk("stored", DW, stored_word);
  endtask : t_read

  task automatic t_xchg();
    int n;
    logic [17:0] e;
    e = {5'h15, 13'h0200};
    @(posedge clk);
    ack_delay <= 12'd700;
    bad_parity_test <= 1'b1;
    repeat (4) @(posedge clk);
    bad_parity_test <= 1'b0;
    start(0, 1'b1, 1'b1, 5'h07, 12'h002, 16'h4200);
    wait_for(4, n);
    chk("wr_word", e, drum_out.write_word);
    chk("wr_par_bad", {17'h0, ^e}, {17'h0, drum_out.write_parity});
    chk("wr_sel", 18'h27, {12'h0, drum_out.write_enable, drum_out.write_field});
    chk("xchg_rd", DW, stored_word);
    wait_for(4, n);
    chk("wr_word2", e + 18'h1, drum_out.write_word);
    chk("wr_par", {17'h0, ~^(e + 18'h1)}, {17'h0, drum_out.write_parity});
    wait_for(1, n);
    chk("no_pe", 18'h0, {16'h0, parity_error_flag, error_status});
  endtask : t_xchg

  task automatic t_lock();
    int n;
    int s;
    @(posedge clk);
    field_lockout <= 32'h00000200;
    s = strobes;
    start(0, 1'b0, 1'b1, 5'h09, 12'h001, 16'h0010);
    wait_for(1, n);
    chk("lock_strobes", 18'(s), 18'(strobes));
    field_lockout <= 32'h00000000;
  endtask : t_lock

  task automatic t_parity();
    int n;
    logic [17:0] w;
    @(posedge clk);
    drum_par <= ^DW;
    start(0, 1'b1, 1'b0, 5'h03, 12'h001, 16'h0020);
    wait_for(1, n);
    drum_par <= ~^DW;
    chk("pe_port", 18'h3, {16'h0, parity_error_flag, error_status});
    readback(w);
    chk("pe_rb", 18'h30000, {w[17:12], 12'h0});
  endtask : t_parity

  task automatic t_timeout();
    int n;
    logic [17:0] w;
    @(posedge clk);
    ack_off <= 1'b1;
    start(0, 1'b1, 1'b0, 5'h00, 12'h001, 16'h0030);
    wait_for(0, n);
    wait_for(1, n);
    chk("to_len", 18'h1, {17'h0, n > drum_pkg::ACK_CYCLES - 6 && n < drum_pkg::ACK_CYCLES + 6});
    ack_off <= 1'b0;
    readback(w);
    chk("te_rb", 18'h28000, {w[17:12], 12'h0});
  endtask : t_timeout

  task automatic t_break();
    int n;
    logic [17:0] w;
    readback(w);
    instr(3, {1'b0, 5'h00, w[11:0] + 12'h003});
    chk("brk_busy", 18'h1, {17'h0, busy});
    chk("brk_clr", 18'h0, {17'h0, transfer_error_flag});
    wait_for(3, n);
    chk("brk_time", 18'h1, {17'h0, n > drum_pkg::WORD_CYCLES && n < 4 * drum_pkg::WORD_CYCLES});
    @(posedge clk);
    #1;
    chk("brk_idle", 18'h0, {17'h0, busy});
  endtask : t_break

  initial
  begin
    reset = 1'b1;
    io_in = 18'h00000;
    pins = 5'h00;
    field_lockout = 32'h00000000;
    bad_parity_test = 1'b0;
    drum_par = ~^DW;
    ack_delay = 12'h000;
    ack_off = 1'b0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    t_readback();
    t_read();
    t_xchg();
    t_lock();
    t_parity();
    t_timeout();
    t_break();
    close_out();
  end
endmodule : tb_top
